// file: rtl/osps_defs.vh
// Shared constants of the off-line switch supervisor: clock, oscillator,
// blanking and minimum on-time figures, restart count and state codes.
// Assumes it is included by bare name from every design file that needs it.
`ifndef OSPS_DEFS_VH
`define OSPS_DEFS_VH

// Clock period of the controller clock, in nanoseconds.
`define OSPS_CLK_PERIOD_NS 8
// Oscillator frequency, in kilohertz, and its period in clock cycles.
`define OSPS_OSC_FREQ_KHZ 100
`define OSPS_OSC_PERIOD_CYC (1000000 / (`OSPS_OSC_FREQ_KHZ * `OSPS_CLK_PERIOD_NS))
// Rising share of the sawtooth, in percent; it caps the duty cycle.
`define OSPS_MAX_DUTY_PCT 65
`define OSPS_RISE_CYC ((`OSPS_OSC_PERIOD_CYC * `OSPS_MAX_DUTY_PCT) / 100)
// Leading edge blanking time, rounded up to whole cycles.
`define OSPS_BLANK_NS 200
`define OSPS_BLANK_CYC ((`OSPS_BLANK_NS + `OSPS_CLK_PERIOD_NS - 1) / `OSPS_CLK_PERIOD_NS)
// Minimum on-time of the modulator, rounded up to whole cycles.
`define OSPS_MIN_ON_NS 400
`define OSPS_MIN_ON_CYC ((`OSPS_MIN_ON_NS + `OSPS_CLK_PERIOD_NS - 1) / `OSPS_CLK_PERIOD_NS)
// Sawtooth counter width and on-time counter width.
`define OSPS_RAMP_W 11
`define OSPS_ON_W 8
// Discharge-charge cycles in one auto-restart, and the counter width.
`define OSPS_RESTART_CYCLES 8
`define OSPS_RESTART_W 3

// Supervisor state codes.
`define OSPS_ST_START 2'h0
`define OSPS_ST_RUN 2'h1
`define OSPS_ST_RESTART 2'h2
`define OSPS_ST_LATCHED 2'h3

`endif

// file: rtl/osps_oscillator.v
// Sawtooth oscillator of the switch controller: a free running count that
// marks the start of each period and the end of its rising share.
// Assumes an active-low reset whose release the parent has synchronised.
`include "osps_defs.vh"

module osps_oscillator #(
  parameter PERIOD_CYC = `OSPS_OSC_PERIOD_CYC,
  parameter RISE_CYC = `OSPS_RISE_CYC,
  parameter RAMP_W = `OSPS_RAMP_W
) (
  input wire i_clock,
  input wire i_rst_n,
  output reg [RAMP_W-1:0] o_ramp,
  output reg o_cycle_start,
  output reg o_rise_end
);

  // Integer forms of the counts, cut to the ramp width on purpose.
  localparam integer LAST_I = PERIOD_CYC - 1;
  localparam integer RISE_I = RISE_CYC;
  localparam [RAMP_W-1:0] LAST = LAST_I[RAMP_W-1:0];
  localparam [RAMP_W-1:0] RISE = RISE_I[RAMP_W-1:0];

  reg [RAMP_W-1:0] ramp_d;

  // Next sawtooth value: wraps to zero after the last count of a period.
  always @* begin
    if (o_ramp == LAST) begin
      ramp_d = {RAMP_W{1'b0}};
    end else begin
      ramp_d = o_ramp + {{(RAMP_W-1){1'b0}}, 1'b1};
    end
  end

  // The start pulse lines up with ramp value zero; the rise end flag is
  // high over the falling share, where no pulse may stay on.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ramp <= {RAMP_W{1'b0}};
      o_cycle_start <= 1'b0;
      o_rise_end <= 1'b0;
    end else begin
      o_ramp <= ramp_d;
      o_cycle_start <= (o_ramp == LAST);
      o_rise_end <= (ramp_d >= RISE);
    end
  end

endmodule

// file: rtl/osps_core.v
// Control logic of a self-biased off-line power switch: start-up, shunt
// regulation, hysteretic auto-restart with an eight-cycle restart count,
// latched shutdown, and the fixed-frequency switch latch with current limit.
// Assumes analog parts (supply thresholds, error filter, current-limit
// comparator, thermal sensor) arrive as levels synchronous to i_clock, and
// that i_resetn is the power-up reset of the device.
`include "osps_defs.vh"

module osps_core #(
  parameter PERIOD_CYC = `OSPS_OSC_PERIOD_CYC,
  parameter RISE_CYC = `OSPS_RISE_CYC,
  parameter BLANK_CYC = `OSPS_BLANK_CYC,
  parameter MIN_ON_CYC = `OSPS_MIN_ON_CYC,
  parameter RESTART_CYCLES = `OSPS_RESTART_CYCLES
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_vc_upper,
  input wire i_vc_lower,
  input wire i_error_cross,
  input wire i_ctrl_above_min,
  input wire i_on_state_switch_voltage_high,
  input wire i_ctrl_overvoltage_pulse,
  input wire i_overtemp,
  output reg o_switch_on,
  output reg o_bias_source_on,
  output reg o_modulator_en,
  output reg o_standby,
  output reg o_overvoltage_latched,
  output reg o_overtemp_latched,
  output reg [`OSPS_RESTART_W-1:0] o_restart_count,
  output wire [`OSPS_RAMP_W-1:0] o_ramp,
  output wire o_cycle_start
);

  // Integer forms of the timing figures, cut to their counters on purpose.
  localparam integer BLANK_I = BLANK_CYC;
  localparam integer MIN_ON_LAST_I = MIN_ON_CYC - 1;
  localparam integer RESTART_LAST_I = RESTART_CYCLES - 1;

  localparam [`OSPS_ON_W-1:0] BLANK = BLANK_I[`OSPS_ON_W-1:0];
  localparam [`OSPS_ON_W-1:0] MIN_ON_LAST = MIN_ON_LAST_I[`OSPS_ON_W-1:0];
  localparam [`OSPS_ON_W-1:0] ON_MAX = {`OSPS_ON_W{1'b1}};
  localparam [`OSPS_RESTART_W-1:0] RESTART_LAST =
    RESTART_LAST_I[`OSPS_RESTART_W-1:0];

  // Reset release pipeline; the rest of the block uses rst_n.
  reg rst_meta_q;
  reg rst_n;

  // Supervisor state and its next value. The state, the bias source and
  // the restart count are decided together, so the bias source never
  // changes without the state it belongs to.
  reg [1:0] state_q;
  reg [1:0] state_d;

  // Next values of the registered outputs. Every output is a flop, so a
  // comparator glitch can never reach the gate drive combinationally.
  // Standby and modulator enable follow the next state one for one.
  reg switch_d;
  reg bias_d;
  reg modulator_d;
  reg standby_d;
  reg ov_d;
  reg ot_d;
  reg [`OSPS_RESTART_W-1:0] count_d;

  // Cycles the switch has been on in the current pulse, saturating.
  reg [`OSPS_ON_W-1:0] on_cnt_q;
  reg [`OSPS_ON_W-1:0] on_cnt_d;

  // Oscillator outputs seen by the switch latch.
  wire rise_end;

  // Decoded conditions used by the switch latch. Each one is a single
  // reason to end or forbid a pulse; the latch below ranks them.
  wire any_latch;
  wire run_ok;
  wire limit_trip;
  wire mod_trip;

  // True for the states in which the bias source cycles on the thresholds.
  // Auto-restart and latched shutdown share this low-current standby.
  function is_hysteretic;
    input [1:0] st;
    begin
      is_hysteretic = (st == `OSPS_ST_RESTART) || (st == `OSPS_ST_LATCHED);
    end
  endfunction

  // Two-stage release of the asynchronous reset; assertion stays immediate.
  // Release passes two flops so that no register leaves reset on an edge
  // that falls close to the power-up reset edge itself.
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Sawtooth source that paces the switching periods.
  osps_oscillator #(
    .PERIOD_CYC(PERIOD_CYC),
    .RISE_CYC(RISE_CYC),
    .RAMP_W(`OSPS_RAMP_W)
  ) u_osc (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .o_ramp(o_ramp),
    .o_cycle_start(o_cycle_start),
    .o_rise_end(rise_end)
  );

  // Switching is allowed only in shunt regulation with the supply above
  // the lower threshold, so a sagging supply drops the switch at once.
  // A fault input acts in its own cycle as well as through its latch, so
  // the switch never stays on for the cycle in which a fault arrives.
  assign any_latch = o_overvoltage_latched || o_overtemp_latched ||
                     i_ctrl_overvoltage_pulse || i_overtemp;
  assign run_ok = (state_q == `OSPS_ST_RUN) && !any_latch && !i_vc_lower;

  // Current limit counts only once the blanking window has passed. The
  // window is measured on the on-time count, so it restarts every pulse.
  assign limit_trip = i_on_state_switch_voltage_high &&
                      (on_cnt_q >= BLANK);

  // The modulator ends a pulse only above the minimum control current and
  // after the minimum on-time, so small error signals cannot shorten it.
  assign mod_trip = i_error_cross && i_ctrl_above_min &&
                    (on_cnt_q >= MIN_ON_LAST);

  // Shutdown latches only set; nothing but the power-up reset clears them.
  // A set and a clear cannot meet in one cycle: the reset is asynchronous
  // and holds every register for as long as it is asserted.
  always @* begin
    ov_d = o_overvoltage_latched | i_ctrl_overvoltage_pulse;
    ot_d = o_overtemp_latched | i_overtemp;
  end

  // Supervisor: start-up, shunt regulation, auto-restart and shutdown.
  always @* begin
    state_d = state_q;
    bias_d = o_bias_source_on;
    count_d = o_restart_count;
    case (state_q)
      `OSPS_ST_START: begin
        // Start-up: the bias source charges the supply; a fault seen
        // already here goes straight to the latched state.
        bias_d = 1'b1;
        if (ov_d || ot_d) begin
          state_d = `OSPS_ST_LATCHED;
          bias_d = !i_vc_upper;
        end else if (i_vc_upper) begin
          // First arrival at the upper threshold starts switching.
          state_d = `OSPS_ST_RUN;
          bias_d = 1'b0;
        end
      end
      `OSPS_ST_RUN: begin
        // Shunt regulation: the feedback current feeds the supply.
        bias_d = 1'b0;
        if (ov_d || ot_d) begin
          // A shutdown latch hands supply regulation to the comparator.
          state_d = `OSPS_ST_LATCHED;
          bias_d = i_vc_lower;
        end else if (i_vc_lower) begin
          // Feedback current lost: the supply sagged to the lower threshold.
          state_d = `OSPS_ST_RESTART;
          bias_d = 1'b1;
          count_d = {`OSPS_RESTART_W{1'b0}};
        end
      end
      `OSPS_ST_RESTART: begin
        // Auto-restart: every full recharge counts one cycle, and a fault
        // ends the restart in the latched state.
        if (ov_d || ot_d) begin
          state_d = `OSPS_ST_LATCHED;
        end
        if (i_vc_lower) begin
          bias_d = 1'b1;
        end else if (i_vc_upper && o_bias_source_on) begin
          // One discharge-charge cycle is complete at the upper threshold.
          bias_d = 1'b0;
          if (o_restart_count == RESTART_LAST && !(ov_d || ot_d)) begin
            // Eighth cycle done: try shunt regulation again.
            state_d = `OSPS_ST_RUN;
            count_d = {`OSPS_RESTART_W{1'b0}};
          end else begin
            count_d = o_restart_count +
                      {{(`OSPS_RESTART_W-1){1'b0}}, 1'b1};
          end
        end
      end
      `OSPS_ST_LATCHED: begin
        // Nothing leaves this state; only the power-up reset does.
        // Supply keeps cycling between the thresholds while latched off.
        if (i_vc_lower) begin
          bias_d = 1'b1;
        end else if (i_vc_upper) begin
          bias_d = 1'b0;
        end
      end
      default: begin
        // Unknown state value (all four codes are used): fall back to start-up with the bias source on.
        state_d = `OSPS_ST_START;
        bias_d = 1'b1;
        count_d = {`OSPS_RESTART_W{1'b0}};
      end
    endcase
    // The on/off share of the bias source follows from the charge and
    // discharge currents; the logic only reacts to the thresholds.
    standby_d = is_hysteretic(state_d);
    modulator_d = (state_d == `OSPS_ST_RUN);
  end

  // Switch latch: set by the oscillator, cleared by the earliest reset term.
  // The set at the period start wins over the pulse-ending terms, which
  // act again once blanking or the minimum on-time has passed.
  always @* begin
    switch_d = o_switch_on;
    if (!run_ok || state_d != `OSPS_ST_RUN) begin
      switch_d = 1'b0;
    end else if (o_cycle_start) begin
      switch_d = 1'b1;
    end else if (o_switch_on) begin
      if (rise_end) begin
        switch_d = 1'b0;
      end else if (limit_trip) begin
        switch_d = 1'b0;
      end else if (mod_trip) begin
        switch_d = 1'b0;
      end
    end
  end

  // On-time count restarts with each pulse and saturates at its top.
  // Saturation keeps a very long pulse from wrapping back into the
  // blanked range, where the current limit would be ignored again.
  always @* begin
    if (!o_switch_on) begin
      on_cnt_d = {`OSPS_ON_W{1'b0}};
    end else if (on_cnt_q == ON_MAX) begin
      on_cnt_d = on_cnt_q;
    end else begin
      on_cnt_d = on_cnt_q + {{(`OSPS_ON_W-1){1'b0}}, 1'b1};
    end
  end

  // State register and registered outputs; reset is the power-up reset.
  // The bias source leaves reset on, so the supply starts charging at once,
  // and the shutdown latches are cleared here and nowhere else.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `OSPS_ST_START;
      o_switch_on <= 1'b0;
      o_bias_source_on <= 1'b1;
      o_modulator_en <= 1'b0;
      o_standby <= 1'b0;
      o_overvoltage_latched <= 1'b0;
      o_overtemp_latched <= 1'b0;
      o_restart_count <= {`OSPS_RESTART_W{1'b0}};
      on_cnt_q <= {`OSPS_ON_W{1'b0}};
    end else begin
      state_q <= state_d;
      o_switch_on <= switch_d;
      o_bias_source_on <= bias_d;
      o_modulator_en <= modulator_d;
      o_standby <= standby_d;
      o_overvoltage_latched <= ov_d;
      o_overtemp_latched <= ot_d;
      o_restart_count <= count_d;
      on_cnt_q <= on_cnt_d;
    end
  end

endmodule

// file: bench/osps_core_properties.sv
// Checker of the switch supervisor: switch latch timing, bias source and
// restart sequence, seen at the core's ports only.
// Assumes it is bound to osps_core and gets its timing parameters.
`include "osps_defs.vh"

module osps_core_props #(
  parameter RISE_CYC = `OSPS_RISE_CYC,
  parameter BLANK_CYC = `OSPS_BLANK_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_vc_upper,
  input wire logic i_vc_lower,
  input wire logic i_on_state_switch_voltage_high,
  input wire logic i_ctrl_overvoltage_pulse,
  input wire logic i_overtemp,
  input wire logic o_switch_on,
  input wire logic o_bias_source_on,
  input wire logic o_modulator_en,
  input wire logic o_standby,
  input wire logic o_overvoltage_latched,
  input wire logic o_overtemp_latched,
  input wire logic [`OSPS_RESTART_W-1:0] o_restart_count,
  input wire logic [`OSPS_RAMP_W-1:0] o_ramp,
  input wire logic o_cycle_start
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] on_len_q;
  wire nofault = !i_ctrl_overvoltage_pulse && !i_overtemp;
  wire calm = nofault && !i_vc_lower;
  wire idle = o_standby && !o_overvoltage_latched && !o_overtemp_latched;

  // Counts the cycles of the present switch pulse.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      on_len_q <= 12'h000;
    else
      on_len_q <= o_switch_on ? on_len_q + 12'h001 : 12'h000;
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // Steps of a pulse and of one restart charge.
  sequence s_on_calm; $rose(o_switch_on) ##0 calm [*2]; endsequence
  sequence s_on_quiet;
    $rose(o_switch_on) ##0 (calm && !i_on_state_switch_voltage_high) [*4];
  endsequence
  sequence s_charge; idle && o_bias_source_on && i_vc_upper && calm; endsequence

  // Supply sequencing, restart count and latched shutdown.
  property p_start;
    !o_modulator_en && !o_standby && i_vc_upper && calm |=>
      o_modulator_en && !o_bias_source_on;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_lower;
    o_modulator_en && i_vc_lower && nofault |=> !o_switch_on &&
      o_bias_source_on && o_standby && o_restart_count == 3'h0;
  endproperty
  a_lower: assert property (p_lower) else $error("standby");
  property p_step;
    s_charge ##0 o_restart_count != 3'h7 |=> !o_bias_source_on &&
      !o_switch_on && o_restart_count == $past(o_restart_count) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("bad count");
  property p_done;
    s_charge ##0 o_restart_count == 3'h7 |=>
      o_modulator_en && !o_standby && o_restart_count == 3'h0;
  endproperty
  a_done: assert property (p_done) else $error("no resume");
  property p_ov;
    i_ctrl_overvoltage_pulse |=> o_overvoltage_latched && !o_switch_on;
  endproperty
  a_ov: assert property (p_ov) else $error("no ov latch");
  property p_ot; i_overtemp |=> o_overtemp_latched && !o_switch_on; endproperty
  a_ot: assert property (p_ot) else $error("no ot latch");

  // Switch latch timing within one oscillator period.
  property p_set; o_cycle_start && o_modulator_en && calm |=> o_switch_on;
  endproperty
  a_set: assert property (p_set) else $error("no set");
  property p_bias; o_switch_on |-> !o_bias_source_on; endproperty
  a_bias: assert property (p_bias) else $error("bias on");
  property p_max; o_switch_on |-> o_ramp <= RISE_CYC + 2; endproperty
  a_max: assert property (p_max) else $error("too long");
  property p_min; s_on_quiet |-> o_switch_on; endproperty
  a_min: assert property (p_min) else $error("too short");
  property p_blank; s_on_calm |=> o_switch_on; endproperty
  a_blank: assert property (p_blank) else $error("not blanked");
  property p_cl;
    o_switch_on && on_len_q >= BLANK_CYC && !o_cycle_start &&
      i_on_state_switch_voltage_high |=> !o_switch_on;
  endproperty
  a_cl: assert property (p_cl) else $error("no limit");
endmodule

bind osps_core osps_core_props #(.RISE_CYC(RISE_CYC),
  .BLANK_CYC(BLANK_CYC)) u_props (.*);

// file: bench/osps_feedback_net.sv
// Feedback network model: its current shows as the filtered error level
// against the ramp, and as the above-minimum flag.
// Assumes the ramp comes from the core and the bench sets the level.
module osps_feedback_net (
  input wire logic i_clock,
  input wire logic [10:0] i_ramp,
  input wire logic [10:0] i_level,
  input wire logic i_fed,
  output logic o_error_cross = 1'b0,
  output logic o_above_min = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // More current means a lower level, so the error crosses earlier.
  always @(posedge i_clock) begin
    o_error_cross <= (i_ramp >= i_level);
    o_above_min <= i_fed;
  end
endmodule

// file: bench/tb_offline_switch_pwm_supervisor.sv
// Bench of the switch supervisor: start-up, pulse widths, restart and
// latched shutdown, with the feedback model on the error inputs.
// Assumes shortened core timing so the run stays brief.
`include "osps_defs.vh"

module tb_offline_switch_pwm_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RISE = 65, BLANK = 3, MIN_ON = 5;
  logic i_clock = 0, i_resetn = 0, i_vc_upper = 0, i_vc_lower = 0;
  logic i_on_state_switch_voltage_high = 0, i_ctrl_overvoltage_pulse = 0;
  logic i_overtemp = 0, fed = 0;
  logic [10:0] level = 11'h7FF;
  wire i_error_cross, i_ctrl_above_min, o_switch_on, o_bias_source_on;
  wire o_modulator_en, o_standby, o_overvoltage_latched, o_overtemp_latched;
  wire o_cycle_start;
  wire [`OSPS_RESTART_W-1:0] o_restart_count;
  wire [`OSPS_RAMP_W-1:0] o_ramp;
  int failures = 0, n_compared = 0, n;

  osps_core #(.PERIOD_CYC(100), .RISE_CYC(RISE), .BLANK_CYC(BLANK),
    .MIN_ON_CYC(MIN_ON)) dut (.*);
  osps_feedback_net fb (.i_clock(i_clock), .i_ramp(o_ramp), .i_level(level),
    .i_fed(fed), .o_error_cross(i_error_cross),
    .o_above_min(i_ctrl_above_min));

  // Clock of 8 ns period.
  initial begin
    forever #4 i_clock = ~i_clock;
  end

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Out of range reports the value against the lower bound.
  task automatic chk_in(input int v, input int lo, input int hi);
    chk((v >= lo && v <= hi) ? lo[11:0] : v[11:0], lo[11:0]);
  endtask

  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask

  // Raises the chosen inputs for one sampled edge: upper, lower, ov, ot.
  task automatic pulse(input logic [3:0] v);
    @(posedge i_clock);
    {i_vc_upper, i_vc_lower, i_ctrl_overvoltage_pulse, i_overtemp} <= v;
    @(posedge i_clock);
    {i_vc_upper, i_vc_lower, i_ctrl_overvoltage_pulse, i_overtemp} <= 4'h0;
    #1;
  endtask

  // Measures the on-time of the next whole switch pulse into n.
  task automatic measure;
    int k;
    for (k = 0; k < 300 && o_switch_on === 1'b1; k++) tick();
    for (k = 0; k < 300 && o_switch_on !== 1'b1; k++) tick();
    for (n = 0; n < 300 && o_switch_on === 1'b1; n++) tick();
  endtask

  task automatic power_up;
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) tick();
  endtask

  task automatic t_start;
    power_up();
    chk({o_bias_source_on, o_modulator_en}, 2'h2);
    pulse(4'h8);
    chk({o_bias_source_on, o_modulator_en, o_standby}, 3'h2);
    $display("test start done");
  endtask

  // Pulse width from maximum down to minimum, then current limit.
  task automatic t_duty;
    fed <= 1'b1;
    measure();
    chk_in(n, RISE - 1, RISE + 2);
    level <= 11'h01E;
    measure();
    chk_in(n, 28, 33);
    level <= 11'h001;
    measure();
    chk_in(n, MIN_ON, MIN_ON + 2);
    fed <= 1'b0;
    measure();
    chk_in(n, RISE - 1, RISE + 2);
    i_on_state_switch_voltage_high <= 1'b1;
    measure();
    chk_in(n, BLANK, BLANK + 2);
    i_on_state_switch_voltage_high <= 1'b0;
    $display("test duty done");
  endtask

  task automatic t_restart;
    int i;
    pulse(4'h4);
    chk({o_switch_on, o_bias_source_on, o_standby, o_restart_count},
      6'h18);
    for (i = 1; i <= 8; i++) begin
      pulse(4'h8);
      chk({o_switch_on, o_bias_source_on, o_modulator_en, o_restart_count},
        {2'h0, i == 8, i[2:0]});
      if (i < 8)
        pulse(4'h4);
      if (i < 8)
        chk(o_bias_source_on, 1'b1);
    end
    measure();
    chk_in(n, RISE - 1, RISE + 2);
    $display("test restart done");
  endtask

  task automatic t_fault;
    int i;
    for (i = 0; i < 2; i++) begin
      pulse(i == 0 ? 4'h2 : 4'h1);
      chk({o_switch_on, o_standby, o_overvoltage_latched, o_overtemp_latched},
        {2'h1, i == 0, i == 1});
      pulse(4'h4);
      chk(o_bias_source_on, 1'b1);
      pulse(4'h8);
      chk({o_bias_source_on, o_modulator_en, o_standby},
        3'h1);
      power_up();
      chk({o_overvoltage_latched, o_overtemp_latched}, 2'h0);
      pulse(4'h8);
      chk(o_modulator_en, 1'b1);
    end
    $display("test fault done");
  endtask

  initial begin
    t_start();
    t_duty();
    t_restart();
    t_fault();
    tally_and_finish();
  end

  // Cuts a hung run short, well beyond the expected run time.
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule
